/* port_cfg_pkg.sv */
// Constants for the port configuration and keypad wake block.
// Assumes a 20 MHz CPU clock and a 32-bit AXI4-Lite register bus.
package port_cfg_pkg;
    ////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NPINS = 36;
    localparam int ADDR_W = 12;
    localparam int NKEYS = 8;
    localparam int NPORTS = 5;
    ////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [11:0] LATCH_LO_OFF = 12'h000;
    localparam logic [11:0] LATCH_HI_OFF = 12'h004;
    localparam logic [11:0] MODE_A_LO_OFF = 12'h008;
    localparam logic [11:0] MODE_A_HI_OFF = 12'h00c;
    localparam logic [11:0] MODE_B_LO_OFF = 12'h010;
    localparam logic [11:0] MODE_B_HI_OFF = 12'h014;
    localparam logic [11:0] PIN_LO_OFF = 12'h018;
    localparam logic [11:0] PIN_HI_OFF = 12'h01c;
    localparam logic [11:0] THRESH_OFF = 12'h020;
    localparam logic [11:0] AUX_TWO_OFF = 12'h024;
    localparam logic [11:0] KEY_EN_OFF = 12'h028;
    localparam logic [11:0] AUX_ONE_INDEX = 12'h0a2;
    localparam logic [11:0] AUX_ONE_OFF = 12'(AUX_ONE_INDEX * 4);
    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int KEY_FLAG_BIT = 7;
    localparam int T0_OE_BIT = 0;
    localparam int T1_OE_BIT = 1;
    localparam int CLKOUT_BIT = 2;
    localparam int KEY_IE_BIT = 3;
    ////////////////////////////////////////////////////////////////////
    // Pin modes, coded as {mode bit a, mode bit b}
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PP = 2'h1;
    localparam logic [1:0] MODE_IN = 2'h2;
    localparam logic [1:0] MODE_OD = 2'h3;
    ////////////////////////////////////////////////////////////////////
    // Special pins, index = port * 8 + bit
    localparam int RST_PIN = 12;
    localparam int I2C_PIN_A = 13;
    localparam int I2C_PIN_B = 14;
    localparam int CLKOUT_PIN = 8;
    localparam int T0_PIN = 30;
    localparam int T1_PIN = 31;
    localparam int KEY_EDGE_LO = 1;
    localparam int KEY_EDGE_HI = 3;
    ////////////////////////////////////////////////////////////////////
    // Timing and reset values
    localparam int STRONG_CYCLES = 2;
    localparam int CLKOUT_DIV = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : port_cfg_pkg

/* port_cfg.sv */
// I/O port mode, pull-up, threshold, alternate output and keypad logic.
// Assumes pins arrive asynchronously, timers and power inputs on aclk,
// and the reset-level and reset-pin straps stable while aresetn is low.
//
// What this block does
// RQ1: Two mode bits per pin pick quasi, push-pull, input or open drain.
// RQ2: Pin 1.4 is never driven; it is input or reset input.
// RQ3: After reset every configurable pin is quasi-bidirectional.
// RQ4: Reset loads all latches high or low from the reset-level strap.
// RQ5: Quasi mode enables very weak pull-up while latch holds one.
// RQ6: Quasi weak pull-up only while latch and sensed pin are one.
// RQ7: Quasi latch rising edge gives strong pull-up for two clocks.
// RQ8: Open drain has no pull-ups and drives low only for latch zero.
// RQ9: Push-pull drives the latch value strongly both ways.
// RQ10: Input-only mode turns the output driver fully off.
// RQ11: One threshold bit per port; one selects Schmitt, zero TTL.
// RQ12: Pin 1.4 always uses a Schmitt input; here schmitt_select is low during reset, up to the first aclk edge after it.
// RQ13: The two I2C pins are always open drain.
// RQ14: Enabled timer toggle outputs flip on each timer overflow.
// RQ15: Clock divided by four may leave on pin 1.0 for RC/external.
// RQ16: Eight key enables; any enabled triggered key sets the flag.
// RQ17: Flag set by hardware raises enabled irq; software clears it.
// RQ18: Keys 1 to 3 detect both edges; others detect low level.
// RQ19: A key event can wake the CPU from idle and power down.
// RQ20: Key flag is bit 7 of aux control one at index a2.
// RQ21: Keys are synchronised first so one event sets flag once.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module port_cfg (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [port_cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [port_cfg_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Port pins
    input wire logic [port_cfg_pkg::NPINS-1:0] pin_in,
    output logic [port_cfg_pkg::NPINS-1:0] pin_out,
    output logic [port_cfg_pkg::NPINS-1:0] pin_oe,
    output logic [port_cfg_pkg::NPINS-1:0] very_weak_pullup,
    output logic [port_cfg_pkg::NPINS-1:0] weak_pullup,
    output logic [port_cfg_pkg::NPINS-1:0] schmitt_select,
    // Nonvolatile configuration straps
    input wire logic reset_level_select,
    input wire logic reset_pin_disable,
    input wire logic clk_src_rc_or_ext,
    // Timers and power state
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic idle_mode,
    input wire logic power_down,
    // Results
    output logic keypad_irq,
    output logic wake_request,
    output logic pin_reset_request
);
    import port_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Storage
    logic [NPINS-1:0] latch, mode_a, mode_b;
    logic [NPINS-1:0] sync_a, sync_b, q1, q2, data;
    logic [1:0] em [NPINS];
    logic [NPORTS-1:0] thresh;
    logic [3:0] aux_control_two;
    logic [NKEYS-1:0] keypad_pin_enables, kb_prev, hits;
    logic keypad_irq_flag, rpd_caught;
    logic t0_tog, t1_tog, div_cnt, clk_div_q, clkout_on;
    logic aw_held, w_held, wr_fire, key_any;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data, rd_word;
    logic [3:0] wr_strb;
    logic [NPINS-1:0] next_oe, next_out, next_vw, next_weak;

    // Mode of a pin after fixed-function overrides
    function automatic logic [1:0] pin_mode(input int i,
                                            input logic a,
                                            input logic b);
        if (i == RST_PIN)
            return MODE_IN; // [RQ2]
        if (i == I2C_PIN_A || i == I2C_PIN_B)
            return MODE_OD; // [RQ13]
        return {a, b}; // [RQ1]
    endfunction : pin_mode

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k])
                r[k*8 +: 8] = nw[k*8 +: 8];
        end
        return r;
    endfunction : merge

    // Decoded address check shared by reads and writes
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        case (a)
            LATCH_LO_OFF, LATCH_HI_OFF, MODE_A_LO_OFF, MODE_A_HI_OFF,
            MODE_B_LO_OFF, MODE_B_HI_OFF, PIN_LO_OFF, PIN_HI_OFF,
            THRESH_OFF, AUX_TWO_OFF, KEY_EN_OFF, AUX_ONE_OFF:
                return 1'b1;
            default:
                return 1'b0;
        endcase
    endfunction : addr_ok

    ////////////////////////////////////////////////////////////////////
    // AXI write channel: one write in flight, address and data any order
    assign wr_fire = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= ZERO_WORD;
            wr_strb <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                wr_addr <= awaddr;
                aw_held <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
                w_held <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= addr_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Latches: reset level from the strap, then software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch <= {NPINS{reset_level_select}}; // [RQ4]
        end else if (wr_fire && wr_addr == LATCH_LO_OFF) begin
            latch[31:0] <= merge(latch[31:0], wr_data, wr_strb);
        end else if (wr_fire && wr_addr == LATCH_HI_OFF && wr_strb[0]) begin
            latch[35:32] <= wr_data[3:0];
        end
    end

    // Mode bits: all quasi-bidirectional after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_a <= '0; // [RQ3]
            mode_b <= '0;
        end else if (wr_fire) begin
            case (wr_addr)
                MODE_A_LO_OFF:
                    mode_a[31:0] <= merge(mode_a[31:0], wr_data, wr_strb);
                MODE_A_HI_OFF:
                    if (wr_strb[0])
                        mode_a[35:32] <= wr_data[3:0];
                MODE_B_LO_OFF:
                    mode_b[31:0] <= merge(mode_b[31:0], wr_data, wr_strb);
                MODE_B_HI_OFF:
                    if (wr_strb[0])
                        mode_b[35:32] <= wr_data[3:0];
                default: ;
            endcase
        end
    end

    // Threshold, alternate output and key enable controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thresh <= '0;
            aux_control_two <= 4'h0;
            keypad_pin_enables <= 8'h00;
        end else if (wr_fire && wr_strb[0]) begin
            case (wr_addr)
                THRESH_OFF: thresh <= wr_data[NPORTS-1:0]; // [RQ11]
                AUX_TWO_OFF: aux_control_two <= wr_data[3:0];
                KEY_EN_OFF: keypad_pin_enables <= wr_data[7:0]; // [RQ16]
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI read channel: answer one cycle after the address is taken
    always_comb begin
        case (araddr)
            LATCH_LO_OFF: rd_word = latch[31:0];
            LATCH_HI_OFF: rd_word = {28'h0, latch[35:32]};
            MODE_A_LO_OFF: rd_word = mode_a[31:0];
            MODE_A_HI_OFF: rd_word = {28'h0, mode_a[35:32]};
            MODE_B_LO_OFF: rd_word = mode_b[31:0];
            MODE_B_HI_OFF: rd_word = {28'h0, mode_b[35:32]};
            PIN_LO_OFF: rd_word = sync_b[31:0];
            PIN_HI_OFF: rd_word = {28'h0, sync_b[35:32]};
            THRESH_OFF: rd_word = {27'h0, thresh};
            AUX_TWO_OFF: rd_word = {28'h0, aux_control_two};
            KEY_EN_OFF: rd_word = {24'h0, keypad_pin_enables};
            AUX_ONE_OFF: rd_word = {24'h0, keypad_irq_flag, 7'h0}; // [RQ20]
            default: rd_word = ZERO_WORD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= ZERO_WORD;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only sync_b is read by logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // Reset-pin strap caught while reset is held
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rpd_caught <= reset_pin_disable;
    end

    // Pin 1.4 low requests a reset when it serves as reset input
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pin_reset_request <= 1'b0;
        else
            pin_reset_request <= !rpd_caught && !sync_b[RST_PIN]; // [RQ2]
    end

    ////////////////////////////////////////////////////////////////////
    // Timer toggles and divide-by-four clock output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t0_tog <= 1'b0;
            t1_tog <= 1'b0;
        end else begin
            if (timer0_overflow)
                t0_tog <= !t0_tog; // [RQ14]
            if (timer1_overflow)
                t1_tog <= !t1_tog; // [RQ14]
        end
    end

    // div_cnt is the half-rate enable pulse; the output flips on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= 1'b0;
            clk_div_q <= 1'b0;
        end else begin
            div_cnt <= !div_cnt;
            if (div_cnt)
                clk_div_q <= !clk_div_q; // [RQ15]
        end
    end

    assign clkout_on = aux_control_two[CLKOUT_BIT] && clk_src_rc_or_ext;

    // Pin data and mode after alternate functions take their pins
    always_comb begin
        data = latch;
        for (int i = 0; i < NPINS; i++)
            em[i] = pin_mode(i, mode_a[i], mode_b[i]);
        if (aux_control_two[T0_OE_BIT]) begin
            data[T0_PIN] = t0_tog; // [RQ14]
            em[T0_PIN] = MODE_PP;
        end
        if (aux_control_two[T1_OE_BIT]) begin
            data[T1_PIN] = t1_tog; // [RQ14]
            em[T1_PIN] = MODE_PP;
        end
        if (clkout_on) begin
            data[CLKOUT_PIN] = clk_div_q; // [RQ15]
            em[CLKOUT_PIN] = MODE_PP;
        end
    end

    // History of pin data for the strong pull-up pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q1 <= {NPINS{reset_level_select}};
            q2 <= {NPINS{reset_level_select}};
        end else begin
            q1 <= data;
            q2 <= q1;
        end
    end

    // Driver decode per pin and mode
    always_comb begin
        next_oe = '0;
        next_out = '0;
        next_vw = '0;
        next_weak = '0;
        for (int i = 0; i < NPINS; i++) begin
            case (em[i])
                MODE_QUASI: begin
                    next_out[i] = data[i];
                    next_oe[i] = !data[i] || !q1[i] || !q2[i]; // [RQ7]
                    next_vw[i] = data[i]; // [RQ5]
                    next_weak[i] = data[i] && sync_b[i]; // [RQ6]
                end
                MODE_PP: begin
                    next_out[i] = data[i]; // [RQ9]
                    next_oe[i] = 1'b1;
                end
                MODE_OD: begin
                    next_oe[i] = !data[i]; // [RQ8]
                end
                default: ; // [RQ10]
            endcase
        end
    end

    // Registered pad controls and input thresholds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
            pin_oe <= '0;
            very_weak_pullup <= '0;
            weak_pullup <= '0;
            schmitt_select <= '0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            very_weak_pullup <= next_vw;
            weak_pullup <= next_weak;
            for (int i = 0; i < NPINS; i++)
                schmitt_select[i] <= thresh[i/8] || i == RST_PIN; // [RQ12]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Keypad detection on synchronised port 0
    always_comb begin
        for (int i = 0; i < NKEYS; i++) begin
            if (i >= KEY_EDGE_LO && i <= KEY_EDGE_HI)
                hits[i] = sync_b[i] ^ kb_prev[i]; // [RQ18] [RQ21]
            else
                hits[i] = !sync_b[i]; // [RQ18]
        end
        hits = hits & keypad_pin_enables; // [RQ16]
    end

    assign key_any = |hits;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            kb_prev <= 8'hff;
        else
            kb_prev <= sync_b[NKEYS-1:0];
    end

    // Sticky flag: a key event wins over a software clear
    always_ff @(posedge aclk) begin
        if (!aresetn)
            keypad_irq_flag <= 1'b0;
        else if (key_any)
            keypad_irq_flag <= 1'b1; // [RQ17]
        else if (wr_fire && wr_addr == AUX_ONE_OFF && wr_strb[0]
                 && !wr_data[KEY_FLAG_BIT])
            keypad_irq_flag <= 1'b0; // [RQ17]
    end

    // Interrupt request and wake from idle or power down
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keypad_irq <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            keypad_irq <= keypad_irq_flag && aux_control_two[KEY_IE_BIT];
            wake_request <= key_any && (idle_mode || power_down); // [RQ19]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks; the mode checks use pin 9, which has no alternate function
    sequence s_quasi_rise;
        em[9] == MODE_QUASI && $rose(data[9]);
    endsequence

    sequence s_held_high;
        (data[9] && em[9] == MODE_QUASI)[*2];
    endsequence

    a_strong_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
        s_quasi_rise |=> pin_oe[9] && pin_out[9])
        else $error("strong pull-up not started");

    a_strong_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
        s_quasi_rise ##1 s_held_high |=> !pin_oe[9])
        else $error("strong pull-up longer than two clocks");

    a_weak_pull: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
        weak_pullup[9] |-> $past(data[9] && sync_b[9]))
        else $error("weak pull-up on without latch and pin high");

    a_very_weak: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
        em[9] == MODE_QUASI && data[9] |=> very_weak_pullup[9])
        else $error("very weak pull-up missing");

    a_push_pull: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9]
        em[9] == MODE_PP |=> pin_oe[9] && pin_out[9] == $past(data[9]))
        else $error("push-pull drive wrong");

    a_open_drain: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
        em[9] == MODE_OD |=> pin_oe[9] != $past(data[9]) && !pin_out[9]
            && !very_weak_pullup[9] && !weak_pullup[9])
        else $error("open drain drive wrong");

    a_input_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ10]
        em[9] == MODE_IN |=> !pin_oe[9] && !very_weak_pullup[9])
        else $error("input-only pin driven");

    a_reset_pin: assert property (@(posedge aclk) // [RQ2]
        disable iff (!aresetn)
        !pin_oe[RST_PIN] && !very_weak_pullup[RST_PIN])
        else $error("reset pin driven");

    a_i2c_no_high: assert property (@(posedge aclk) // [RQ13]
        disable iff (!aresetn)
        !(pin_oe[I2C_PIN_A] && pin_out[I2C_PIN_A])
        && !(pin_oe[I2C_PIN_B] && pin_out[I2C_PIN_B]))
        else $error("I2C pin driven high");

    a_reset_state: assert property (@(posedge aclk) // [RQ3] [RQ4]
        $past(!aresetn) |-> mode_a == '0 && mode_b == '0
            && latch == {NPINS{$past(reset_level_select)}})
        else $error("reset state wrong");

    a_reset_schmitt: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ12]
        $past(aresetn) |-> schmitt_select[RST_PIN])
        else $error("reset pin not Schmitt");

    a_key_edge: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ18]
        keypad_pin_enables[1] && sync_b[1] != kb_prev[1]
            |=> keypad_irq_flag)
        else $error("key edge missed");

    a_timer_flip: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14]
        aux_control_two[T0_OE_BIT] && timer0_overflow
            |=> ##1 pin_out[T0_PIN] != $past(pin_out[T0_PIN]))
        else $error("timer toggle missed");

    a_clkout_rate: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ15]
        clkout_on [*4] |-> pin_out[CLKOUT_PIN] != $past(pin_out[CLKOUT_PIN], 2))
        else $error("clock output not divided by four");

endmodule : port_cfg

/* pad_model.sv */
// Board side of the port pins: external loads, keypad keys and pull-ups.
// Assumes pad controls change only on rising edges of aclk.
`timescale 1ns/1ps
module pad_model #(
    parameter logic [35:0] BOARD_PU = 36'h0_0000_7000
) (
    // Clock
    input wire logic aclk,
    // Pad controls from the port logic
    input wire logic [port_cfg_pkg::NPINS-1:0] pin_out,
    input wire logic [port_cfg_pkg::NPINS-1:0] pin_oe,
    input wire logic [port_cfg_pkg::NPINS-1:0] very_weak_pullup,
    input wire logic [port_cfg_pkg::NPINS-1:0] weak_pullup,
    // Keys or loads sinking a pin
    input wire logic [port_cfg_pkg::NPINS-1:0] ext_low,
    // Resolved pin levels
    output logic [port_cfg_pkg::NPINS-1:0] pin_in
);
    import port_cfg_pkg::*;
    logic [NPINS-1:0] last = '0;
    ////////////////////////////////////////////////////////////////////
    // Floating pins show their last level inverted
    always_ff @(posedge aclk) begin
        last <= pin_in;
    end
    // Strong drive wins, then a pressed key, then any pull-up
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_low[i])
                pin_in[i] = 1'b0;
            else if (very_weak_pullup[i] || weak_pullup[i] || BOARD_PU[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = ~last[i];
        end
    end
endmodule : pad_model

/* tb_top.sv */
// Self-checking bench for the port configuration and keypad block.
// Assumes the design package and the pad model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import port_cfg_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_d;
    logic [3:0] wstrb = 4'hf, hs;
    logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_r;
    logic [35:0] pin_in, pin_out, pin_oe, very_weak_pullup, weak_pullup;
    logic [35:0] schmitt_select, ext_low = '0;
    logic reset_level_select = 1, reset_pin_disable = 0;
    logic clk_src_rc_or_ext = 1, idle_mode = 0, power_down = 0;
    logic timer0_overflow = 0, timer1_overflow = 0, wake_seen = 0;
    logic keypad_irq, wake_request, pin_reset_request;
    int errors = 0, cmp_count = 0, strong_cnt = 0;
    port_cfg port_cfg_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pin_in,
        .pin_out, .pin_oe, .very_weak_pullup, .weak_pullup, .schmitt_select,
        .reset_level_select, .reset_pin_disable, .clk_src_rc_or_ext,
        .timer0_overflow, .timer1_overflow, .idle_mode, .power_down,
        .keypad_irq, .wake_request, .pin_reset_request);
    pad_model pad_model_inst (.aclk, .pin_out, .pin_oe, .very_weak_pullup,
        .weak_pullup, .ext_low, .pin_in);
    ////////////////////////////////////////////////////////////////////
    // Clock, strong-high counter on pin 0, wake catcher
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        if (pin_oe[0] && pin_out[0]) strong_cnt <= strong_cnt + 1;
        if (wake_request) wake_seen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bus write and read; bready, rready stay high
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk); hs[2:0] = {awready, wready, bvalid};
            @(posedge aclk); if (hs[2]) awvalid <= 0;
            if (hs[1]) wvalid <= 0; if (hs[0]) break;
        end
        if (n == 50) begin chk(0, 1); finish_test(); end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int n;
        araddr <= a; arvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk); hs[1:0] = {arready, rvalid};
            rd_d = rdata; rd_r = rresp;
            @(posedge aclk); if (hs[1]) arvalid <= 0;
            if (hs[0]) break;
        end
        if (n == 50) begin chk(0, 1); finish_test(); end
    endtask : rd
    ////////////////////////////////////////////////////////////////////
    task automatic t_pads();
        logic [1:0] m;
        chk({pin_oe, very_weak_pullup[0], weak_pullup[0]}, 38'h3);
        chk(schmitt_select, 36'h1000);
        ext_low[0] <= 1; repeat (5) @(posedge aclk);
        chk({very_weak_pullup[0], weak_pullup[0]}, 2'b10);
        ext_low[0] <= 0; wr(LATCH_LO_OFF, 32'hffff_fffe);
        repeat (2) @(posedge aclk);
        chk({pin_oe[0], pin_out[0]}, 2'b10);
        strong_cnt = 0; wr(LATCH_LO_OFF, 32'hffff_ffff);
        repeat (6) @(posedge aclk);
        chk({strong_cnt[3:0], pin_oe[0]}, 5'h4);
        for (int i = 1; i < 4; i++) begin
            m = 2'(i);
            wr(MODE_A_LO_OFF, {22'h0, m[1], 8'h0, m[1]});
            wr(MODE_B_LO_OFF, {22'h0, m[0], 8'h0, m[0]});
            repeat (2) @(posedge aclk);
            if (m == MODE_PP) chk({pin_oe[0], pin_out[0]}, 2'b11);
            else chk({pin_oe[0], very_weak_pullup[0], weak_pullup[0]}, 0);
        end
        wr(LATCH_LO_OFF, 32'hffff_fffe); repeat (2) @(posedge aclk);
        chk({pin_oe[0], pin_out[0]}, 2'b10);
        wr(MODE_A_LO_OFF, 0); wr(MODE_B_LO_OFF, '1); wr(LATCH_LO_OFF, '1);
        repeat (2) @(posedge aclk);
        chk(pin_oe[14:11], 4'b0001);
        wr(MODE_B_LO_OFF, 0); wr(THRESH_OFF, 32'h2); repeat (2) @(posedge aclk);
        chk(schmitt_select, 36'hff00);
    endtask : t_pads
    task automatic t_alt();
        logic [1:0] v;
        logic p;
        int n;
        wr(AUX_TWO_OFF, 32'h7); repeat (2) @(posedge aclk);
        v = pin_out[31:30];
        timer0_overflow <= 1; timer1_overflow <= 1; @(posedge aclk);
        timer0_overflow <= 0; timer1_overflow <= 0; repeat (2) @(posedge aclk);
        chk({pin_oe[31:30], pin_out[31:30]}, {2'b11, ~v});
        p = pin_out[8]; n = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge aclk);
            if (pin_out[8] !== p) n++;
            p = pin_out[8];
        end
        chk(n[3:0], 4'h8);
    endtask : t_alt
    task automatic t_keys();
        wr(AUX_TWO_OFF, 32'h8); wr(KEY_EN_OFF, 32'h2);
        ext_low[4] <= 1; repeat (5) @(posedge aclk); rd(AUX_ONE_OFF);
        chk({keypad_irq, rd_d}, 0);
        ext_low[4] <= 0; idle_mode <= 1; ext_low[1] <= 1; repeat (6) @(posedge aclk);
        chk({keypad_irq, wake_seen}, 2'b11);
        rd(AUX_ONE_OFF); chk(rd_d, 32'h80);
        wr(AUX_ONE_OFF, 0); repeat (3) @(posedge aclk);
        chk(keypad_irq, 0);
        idle_mode <= 0; power_down <= 1; wake_seen = 0;
        ext_low[1] <= 0; repeat (6) @(posedge aclk);
        chk({keypad_irq, wake_seen}, 2'b11);
        power_down <= 0; rd(12'h100);
        chk({rd_r, rd_d}, {RESP_SLVERR, ZERO_WORD});
    endtask : t_keys
    // Reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        repeat (5) @(posedge aclk);
        t_pads();
        t_alt();
        t_keys();
        finish_test();
    end
endmodule : tb_top
